//--- core/scpm_pkg.sv
package scpm_pkg;

	// Clock control register 0 fields
	localparam int CTRL0_CLOCK_OUTPUT_PIN_SEL_LSB  = 0;
	localparam int CTRL0_WAIT_PERIPH_STP = 2;
	localparam int CTRL0_SUBCLK_PIN_SEL  = 4;
	localparam int CTRL0_MAIN_OSC_STOP   = 5;
	localparam int CTRL0_DIV_SEL0        = 6;
	localparam int CTRL0_SYS_CLK_SRC     = 7;
	localparam logic [7:0] CTRL0_RESET   = 8'h48;

	// Clock control register 1 fields
	localparam int CTRL1_ALL_CLK_STOP    = 0;
	localparam int CTRL1_DIV_SEL1_LSB    = 6;
	localparam logic [7:0] CTRL1_RESET   = 8'h20;

	// Clock output select codes
	localparam logic [1:0] CLOCK_OUTPUT_PIN_PORT   = 2'h0;
	localparam logic [1:0] CLOCK_OUTPUT_PIN_SUB    = 2'h1;
	localparam logic [1:0] CLOCK_OUTPUT_PIN_DIV8   = 2'h2;
	localparam logic [1:0] CLOCK_OUTPUT_PIN_DIV32  = 2'h3;

	// Division select 1 codes
	localparam logic [1:0] DIV1_NONE     = 2'h0;
	localparam logic [1:0] DIV1_BY2      = 2'h1;
	localparam logic [1:0] DIV1_BY4      = 2'h2;
	localparam logic [1:0] DIV1_BY16     = 2'h3;

	// Prescaler width and the bit positions of the div8 and div32 output clocks
	localparam int PRESC_W               = 5;
	localparam int PRESC_DIV8_BIT        = 2;
	localparam int PRESC_DIV32_BIT       = 4;

	// Bus clock source selection
	typedef enum logic [2:0] {
		SCPM_SRC_DIV1,
		SCPM_SRC_DIV2,
		SCPM_SRC_DIV4,
		SCPM_SRC_DIV8,
		SCPM_SRC_DIV16,
		SCPM_SRC_SUB
	} scpm_src_type;

	// Power state
	typedef enum logic [1:0] {
		SCPM_RUN,
		SCPM_WAIT,
		SCPM_STOP
	} scpm_pwr_type;

endpackage

//--- core/scpm_presc_if.sv
`timescale 1ns/100ps
interface scpm_presc_if;
	import scpm_pkg::*;

	logic               run;
	logic [PRESC_W-1:0] count;

	modport core (output run, input count);
	modport presc (input run, output count);
endinterface

//--- core/scpm_prescaler.sv
`timescale 1ns/100ps
module scpm_prescaler
	import scpm_pkg::*;
(
	input  wire logic  i_clk,
	input  wire logic  i_sys_rst,
	scpm_presc_if.presc p
);

	// Free-running main clock prescaler; holds its count while the oscillator is off
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			p.count <= '0;
		end else if (p.run) begin
			p.count <= p.count + 1'b1;
		end
	end

endmodule

//--- core/scpm_clock_power.sv
`timescale 1ns/100ps
// Contract
// [RQ1] Clock output select field routes div8, div32 or sub clock in single-chip mode.
// [RQ2] With peripheral stop bit set, wait freezes div8/div32 clock output.
// [RQ3] Writing one to all-clock stop bit stops oscillators, enters stop mode.
// [RQ4] Stop mode halts bus, peripheral, sub-derived and converter clocks, watchdog too.
// [RQ5] In stop, only external-pulse timers and external-clock serial units run.
// [RQ6] Stop ends on reset or interrupt; software enables the wake interrupt first.
// [RQ7] Entering stop forces division select bit 0 to one.
// [RQ8] Stop with memory expansion: strobes, bus clock, ALE high; bus lines held.
// [RQ9] Single-chip stop: sub clock output high, div8/div32 output keeps level.
// [RQ10] Wait stops bus clock and watchdog; oscillators keep running.
// [RQ11] Peripheral stop bit set at wait gates peripheral clocks during wait.
// [RQ12] Wait ends on reset or interrupt; resumes with bus clock source selected before.
// [RQ13] Wait with memory expansion: strobes, bus clock, ALE high; bus lines held.
// [RQ14] Single-chip wait: sub output runs; div8/div32 runs unless stop bit set.
// [RQ15] After reset bus clock is main clock divided by eight.
// [RQ16] Division select 1 picks divide 1, 2, 4 or 16 when others zero.
// [RQ17] Source select zero and division bit 0 one give divide by eight.
// [RQ18] Source select and sub pin select one, main stop zero: sub clock bus.
// [RQ19] All three bits one: sub clock bus and main oscillator stopped.
// [RQ20] Software waits for oscillator stability before leaving divide-by-eight or low-speed.
// [RQ21] Software allows sub clock two to three seconds settling after start.
module scpm_clock_power
	import scpm_pkg::*;
#(
	parameter int ADDR_W = 20,
	parameter int DATA_W = 16,
	parameter int CS_W   = 4,
	parameter int PORT_W = 8
) (
	input  wire logic              i_clk,
	input  wire logic              i_sys_rst,
	input  wire logic              i_single_chip,
	input  wire logic              i_ctrl0_wr,
	input  wire logic [7:0]        i_ctrl0_data,
	input  wire logic              i_ctrl1_wr,
	input  wire logic [7:0]        i_ctrl1_data,
	input  wire logic              i_wait_exec,
	input  wire logic              i_wake_irq,
	input  wire logic              i_sub_clock,
	input  wire logic [6:0]        i_strobe_n,
	input  wire logic [ADDR_W-1:0] i_bus_addr,
	input  wire logic [DATA_W-1:0] i_bus_data,
	input  wire logic [CS_W-1:0]   i_chip_select_lines,
	input  wire logic [PORT_W-1:0] i_port,
	output logic [7:0]             o_ctrl0,
	output logic [7:0]             o_ctrl1,
	output logic                   o_stop_mode,
	output logic                   o_wait_mode,
	output logic                   o_bus_clk_tick,
	output logic                   o_bus_clk_level,
	output logic                   o_periph_clk_en,
	output logic                   o_converter_clk_en,
	output logic                   o_wdt_clk_en,
	output logic                   o_ext_source_only,
	output logic                   o_main_osc_en,
	output logic                   o_sub_osc_en,
	output logic                   o_clock_output_pin,
	output logic                   o_clock_output_pin_oe,
	output logic [6:0]             o_strobe_n,
	output logic [ADDR_W-1:0]      o_bus_addr,
	output logic [DATA_W-1:0]      o_bus_data,
	output logic [CS_W-1:0]        o_chip_select_lines,
	output logic [PORT_W-1:0]      o_port
);

	// Refuse widths the pin hold logic cannot serve
	if (ADDR_W < 1 || DATA_W < 1 || CS_W < 1 || PORT_W < 1) begin : g_chk
		$error("scpm_clock_power: pin widths must be at least one");
	end

	scpm_presc_if presc_bus ();

	scpm_prescaler u_presc (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.p         (presc_bus.presc)
	);

	logic [7:0]   ctrl0;
	logic [7:0]   ctrl1;
	scpm_pwr_type pwr;
	logic         wait_periph_stop;
	logic         sub_s1;
	logic         sub_s2;
	logic         sub_s3;
	logic         clock_output_pin_hold;

	// Decoded control fields
	wire logic [1:0] clock_output_pin_sel   = ctrl0[CTRL0_CLOCK_OUTPUT_PIN_SEL_LSB +: 2];
	wire logic       src_sub      = ctrl0[CTRL0_SYS_CLK_SRC];
	wire logic       div_sel0     = ctrl0[CTRL0_DIV_SEL0];
	wire logic       main_stop    = ctrl0[CTRL0_MAIN_OSC_STOP];
	wire logic       sub_pin_sel  = ctrl0[CTRL0_SUBCLK_PIN_SEL];
	wire logic [1:0] div_sel1     = ctrl1[CTRL1_DIV_SEL1_LSB +: 2];
	wire logic       in_stop      = (pwr == SCPM_STOP);
	wire logic       in_wait      = (pwr == SCPM_WAIT);
	wire logic       low_power    = in_stop | in_wait;
	wire logic       stop_request = i_ctrl1_wr & i_ctrl1_data[CTRL1_ALL_CLK_STOP];

	// Divided-clock ticks: the count's low bits all ones marks one cycle per period
	logic [PRESC_W-1:0] div_tick;
	genvar k;
	for (k = 0; k < PRESC_W; k++) begin : g_tick
		assign div_tick[k] = &presc_bus.count[k:0];
	end

	// Sub clock rising edge, read only from the second synchroniser stage onward
	wire logic sub_tick = sub_s2 & ~sub_s3;

	// Bus clock source decode
	scpm_src_type src;
	always_comb begin
		// [RQ18] [RQ19] sub clock source
		if (src_sub) begin
			src = SCPM_SRC_SUB;
		// [RQ17] [RQ15] fixed divide by eight
		end else if (div_sel0) begin
			src = SCPM_SRC_DIV8;
		end else begin
			// [RQ16] division select 1
			case (div_sel1)
				DIV1_NONE: src = SCPM_SRC_DIV1;
				DIV1_BY2:  src = SCPM_SRC_DIV2;
				DIV1_BY4:  src = SCPM_SRC_DIV4;
				DIV1_BY16: src = SCPM_SRC_DIV16;
				default:   src = SCPM_SRC_DIV8;
			endcase
		end
	end

	// Tick and pin level of the selected source; a stopped main oscillator gives none
	logic src_tick;
	logic src_level;
	always_comb begin
		case (src)
			SCPM_SRC_DIV1: begin
				src_tick  = 1'b1;
				src_level = presc_bus.count[0];
			end
			SCPM_SRC_DIV2: begin
				src_tick  = div_tick[0];
				src_level = presc_bus.count[0];
			end
			SCPM_SRC_DIV4: begin
				src_tick  = div_tick[1];
				src_level = presc_bus.count[1];
			end
			SCPM_SRC_DIV8: begin
				src_tick  = div_tick[2];
				src_level = presc_bus.count[2];
			end
			SCPM_SRC_DIV16: begin
				src_tick  = div_tick[3];
				src_level = presc_bus.count[3];
			end
			SCPM_SRC_SUB: begin
				src_tick  = sub_tick;
				src_level = sub_s2;
			end
			default: begin
				src_tick  = 1'b0;
				src_level = 1'b1;
			end
		endcase
	end
	wire logic main_src_dead = (src != SCPM_SRC_SUB) & main_stop;

	// [RQ3] [RQ4] oscillators stop in stop mode; main also stops on its own stop bit
	assign presc_bus.run = ~in_stop & ~main_stop;

	// Clock output pin level for the selected source
	logic clock_output_pin_next;
	logic clock_output_pin_freeze;
	always_comb begin
		clock_output_pin_freeze = 1'b0;
		case (clock_output_pin_sel)
			// [RQ9] [RQ14] sub output high in stop, runs in wait
			CLOCK_OUTPUT_PIN_SUB:   clock_output_pin_next = in_stop ? 1'b1 : sub_s2;
			// [RQ1] divided prescaler clocks
			CLOCK_OUTPUT_PIN_DIV8: begin
				clock_output_pin_next   = presc_bus.count[PRESC_DIV8_BIT];
				clock_output_pin_freeze = 1'b1;
			end
			CLOCK_OUTPUT_PIN_DIV32: begin
				clock_output_pin_next   = presc_bus.count[PRESC_DIV32_BIT];
				clock_output_pin_freeze = 1'b1;
			end
			default:      clock_output_pin_next = 1'b0;
		endcase
	end
	// [RQ2] [RQ9] [RQ14] divided outputs keep their level in stop, or in wait with stop bit
	assign clock_output_pin_hold = clock_output_pin_freeze & (in_stop | (in_wait & wait_periph_stop));

	// Two-stage synchroniser and edge stage for the sub clock pin
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			sub_s1 <= 1'b0;
			sub_s2 <= 1'b0;
			sub_s3 <= 1'b0;
		end else begin
			sub_s1 <= i_sub_clock;
			sub_s2 <= sub_s1;
			sub_s3 <= sub_s2;
		end
	end

	// Control registers; writes are ignored while the CPU is halted
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			ctrl0 <= CTRL0_RESET;
			ctrl1 <= CTRL1_RESET;
		end else if (stop_request && pwr == SCPM_RUN) begin
			ctrl1 <= i_ctrl1_data;
			// [RQ7] division select bit 0 forced on stop entry
			ctrl0[CTRL0_DIV_SEL0] <= 1'b1;
		end else if (in_stop && i_wake_irq) begin
			// Stop bit drops as the device wakes
			ctrl1[CTRL1_ALL_CLK_STOP] <= 1'b0;
		end else if (pwr == SCPM_RUN) begin
			if (i_ctrl0_wr) begin
				ctrl0 <= i_ctrl0_data;
			end
			if (i_ctrl1_wr) begin
				ctrl1 <= i_ctrl1_data;
			end
		end
	end

	// Power state sequencing
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			pwr              <= SCPM_RUN;
			wait_periph_stop <= 1'b0;
		end else begin
			case (pwr)
				SCPM_RUN: begin
					// [RQ3] stop entry
					if (stop_request) begin
						pwr <= SCPM_STOP;
					// [RQ10] [RQ11] wait entry latches the peripheral stop bit
					end else if (i_wait_exec) begin
						pwr              <= SCPM_WAIT;
						wait_periph_stop <= ctrl0[CTRL0_WAIT_PERIPH_STP];
					end
				end
				// [RQ6] [RQ12] interrupt wake; source registers untouched in wait
				SCPM_WAIT: begin
					if (i_wake_irq) begin
						pwr <= SCPM_RUN;
					end
				end
				SCPM_STOP: begin
					if (i_wake_irq) begin
						pwr <= SCPM_RUN;
					end
				end
				default: pwr <= SCPM_RUN;
			endcase
		end
	end

	// Clock enables and status outputs
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_stop_mode        <= 1'b0;
			o_wait_mode        <= 1'b0;
			o_bus_clk_tick     <= 1'b0;
			o_periph_clk_en    <= 1'b1;
			o_converter_clk_en <= 1'b1;
			o_wdt_clk_en       <= 1'b1;
			o_ext_source_only  <= 1'b0;
			o_main_osc_en      <= 1'b1;
			o_sub_osc_en       <= 1'b1;
		end else begin
			o_stop_mode        <= in_stop;
			o_wait_mode        <= in_wait;
			// [RQ4] [RQ10] bus clock halted in both low-power states
			o_bus_clk_tick     <= ~low_power & ~main_src_dead & src_tick;
			// [RQ4] [RQ11] peripheral and converter clocks
			o_periph_clk_en    <= ~in_stop & ~(in_wait & wait_periph_stop);
			o_converter_clk_en <= ~in_stop & ~(in_wait & wait_periph_stop);
			// [RQ10] watchdog halted
			o_wdt_clk_en       <= ~low_power;
			// [RQ5] only externally clocked timers and serial units
			o_ext_source_only  <= in_stop;
			// [RQ19] main oscillator off
			o_main_osc_en      <= ~in_stop & ~main_stop;
			o_sub_osc_en       <= ~in_stop;
		end
	end

	// Pin behaviour; the bus clock pin follows a counter bit for main-clock sources, so divide-by-1 shows half rate
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_bus_clk_level       <= 1'b1;
			o_strobe_n            <= '1;
			o_bus_addr            <= '0;
			o_bus_data            <= '0;
			o_chip_select_lines   <= '1;
			o_port                <= '0;
			o_clock_output_pin    <= 1'b0;
			o_clock_output_pin_oe <= 1'b0;
		end else begin
			// [RQ8] [RQ13] strobes and bus clock high, bus lines and ports held
			o_bus_clk_level <= low_power ? 1'b1 : src_level;
			o_strobe_n      <= low_power ? '1 : i_strobe_n;
			if (!low_power) begin
				o_bus_addr          <= i_bus_addr;
				o_bus_data          <= i_bus_data;
				o_chip_select_lines <= i_chip_select_lines;
				o_port              <= i_port;
			end
			// [RQ1] clock output only in single-chip mode
			o_clock_output_pin_oe <= i_single_chip & (clock_output_pin_sel != CLOCK_OUTPUT_PIN_PORT);
			if (!clock_output_pin_hold) begin
				o_clock_output_pin <= i_single_chip & clock_output_pin_next;
			end
		end
	end

	assign o_ctrl0 = ctrl0;
	assign o_ctrl1 = ctrl1;

endmodule

//--- test/scpm_chk_assertions.sv
`timescale 1ns/100ps
module scpm_chk #(
	parameter int PORT_W = 8
) (
	input wire logic              i_clk,
	input wire logic              i_sys_rst,
	input wire logic              i_single_chip,
	input wire logic              i_ctrl1_wr,
	input wire logic [7:0]        i_ctrl1_data,
	input wire logic              i_wake_irq,
	input wire logic [7:0]        o_ctrl0,
	input wire logic [7:0]        o_ctrl1,
	input wire logic              o_stop_mode,
	input wire logic              o_wait_mode,
	input wire logic              o_bus_clk_tick,
	input wire logic              o_bus_clk_level,
	input wire logic              o_periph_clk_en,
	input wire logic              o_converter_clk_en,
	input wire logic              o_wdt_clk_en,
	input wire logic              o_ext_source_only,
	input wire logic              o_sub_osc_en,
	input wire logic              o_clock_output_pin,
	input wire logic [6:0]        o_strobe_n,
	input wire logic [PORT_W-1:0] o_port
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	// Tick spacing is judged only after a quiet spell, since the prescaler phase jumps on a change
	logic [4:0] cfg_q;
	logic [1:0] settle;
	logic [4:0] gap;
	logic       armed;
	wire  [4:0] cfg     = {o_ctrl0[7:5], o_ctrl1[7:6]};
	wire  [4:0] exp_div = o_ctrl0[6] ? 5'h08 : (&o_ctrl1[7:6]) ? 5'h10 : 5'h01 << o_ctrl1[7:6];
	wire        low     = o_stop_mode || o_wait_mode;
	wire        frz     = (o_wait_mode && o_ctrl0[2]) || o_stop_mode;

	// Gap counter and settle timer
	always_ff @(posedge i_clk) begin
		cfg_q <= cfg;
		gap <= o_bus_clk_tick ? 5'h01 : gap + 5'h01;
		armed <= (settle == 2'h0) && (o_bus_clk_tick || armed);
		if (i_sys_rst || cfg != cfg_q || low)
			settle <= 2'h3;
		else if (settle != 2'h0)
			settle <= settle - 2'h1;
	end

	sequence s_stop_seen;
		o_ctrl0[6] && o_ctrl1[0] ##1 o_stop_mode;
	endsequence
	sequence s_wake_done;
		!o_ctrl1[0] ##1 !low;
	endsequence

	property p_stop_entry;
		i_ctrl1_wr && i_ctrl1_data[0] && !low |=> s_stop_seen;
	endproperty
	property p_stop_clk;
		o_stop_mode |-> !o_bus_clk_tick && !o_converter_clk_en && !o_wdt_clk_en && !o_periph_clk_en && o_ext_source_only;
	endproperty
	property p_stop_pins;
		low && !i_single_chip |-> (&o_strobe_n) && o_bus_clk_level;
	endproperty
	property p_hold;
		low && $past(low) |-> $stable(o_port);
	endproperty
	property p_wake;
		low && i_wake_irq |=> s_wake_done;
	endproperty
	property p_wait_clk;
		o_wait_mode |-> !o_bus_clk_tick && !o_wdt_clk_en && o_sub_osc_en && (o_periph_clk_en != o_ctrl0[2]);
	endproperty
	property p_clk_frz;
		i_single_chip && o_ctrl0[1] && frz && $past(frz) |-> $stable(o_clock_output_pin);
	endproperty
	property p_div;
		o_bus_clk_tick && armed && settle == 2'h0 && cfg == cfg_q && !cfg[4] && !cfg[2] && !low |-> gap == exp_div;
	endproperty

	a_stop_entry: assert property (p_stop_entry) else $error("stop entry wrong");
	a_stop_clk: assert property (p_stop_clk) else $error("clock running in stop");
	a_stop_pins: assert property (p_stop_pins) else $error("strobes not high in low power");
	a_hold: assert property (p_hold) else $error("port moved in low power");
	a_wake: assert property (p_wake) else $error("wake not taken");
	a_wait_clk: assert property (p_wait_clk) else $error("wait clocks wrong");
	a_clk_frz: assert property (p_clk_frz) else $error("clock output not frozen");
	a_div: assert property (p_div) else $error("bus tick spacing wrong");
endmodule

//--- test/tb.sv
`timescale 1ns/100ps
module tb;
	import scpm_pkg::*;
	logic i_clk, i_sys_rst, i_single_chip, i_ctrl0_wr, i_ctrl1_wr, i_wait_exec, i_wake_irq, i_sub_clock, hold;
	logic [7:0] i_ctrl0_data, i_ctrl1_data, i_port, o_ctrl0, o_ctrl1, o_port, va, vp, vd, vc;
	logic [6:0] i_strobe_n, o_strobe_n;
	logic [19:0] i_bus_addr, o_bus_addr;
	logic [15:0] i_bus_data, o_bus_data;
	logic [3:0] i_chip_select_lines, o_chip_select_lines;
	logic o_stop_mode, o_wait_mode, o_bus_clk_tick, o_bus_clk_level, o_periph_clk_en, o_converter_clk_en;
	logic o_wdt_clk_en, o_ext_source_only, o_main_osc_en, o_sub_osc_en, o_clock_output_pin, o_clock_output_pin_oe;
	logic [31:0] lfsr = 32'h0991;
	logic [4:0] cnt = 5'h00;
	logic [4:0] gap = 5'h00;
	// Clock output pin edge count and pin level seen at the previous falling edge
	logic [7:0] tog = 8'h00;
	logic pin_q = 1'b0;
	// Pin changes over 80 edges: port, sub (half period 5), div8 (half 4), div32 (half 16)
	logic [7:0] tog_exp[4] = '{8'h00, 8'h10, 8'h14, 8'h05};
	int fails, n_tests, cyc, sc;
	typedef struct {int id; logic [7:0] e; logic [7:0] m;} scpm_note_type;
	scpm_note_type q[$];
	string nm[11] = '{"ctrl0", "ctrl1", "gap", "status", "pin", "strobe", "addr", "port", "toggles", "data", "cs"};

	scpm_clock_power DUT (.*);

	initial begin
		i_clk = 0;
		forever #4 i_clk = !i_clk;
	end

	// Next state of the stimulus shift register
	function automatic logic [31:0] lfsr_next(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Random bus traffic and a slow sub clock of ten cycles
	always @(posedge i_clk) begin
		#1;
		lfsr = lfsr_next(lfsr);
		sc = (sc == 4) ? 0 : sc + 1;
		if (sc == 0)
			i_sub_clock = !i_sub_clock;
		if (!hold) begin
			i_bus_addr = lfsr[19:0];
			i_bus_data = lfsr[31:16];
			i_port = lfsr[31:24];
			i_strobe_n = lfsr[6:0];
			i_chip_select_lines = lfsr[3:0];
		end
	end

	function automatic logic [7:0] val(int id);
		case (id)
			0: return o_ctrl0;
			1: return o_ctrl1;
			2: return {3'h0, gap};
			3: return {o_stop_mode, o_wait_mode, o_periph_clk_en, o_converter_clk_en,
				o_wdt_clk_en, o_ext_source_only, o_main_osc_en, o_sub_osc_en};
			4: return {o_clock_output_pin_oe, o_clock_output_pin, o_bus_clk_level, 5'h00};
			5: return {1'b0, o_strobe_n};
			6: return o_bus_addr[7:0];
			7: return o_port;
			8: return tog;
			9: return o_bus_data[7:0];
			default: return {4'h0, o_chip_select_lines};
		endcase
	endfunction

	task automatic check(int id, logic [7:0] s, logic [7:0] e);
		n_tests++;
		if (s !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm[id], e, s);
		end
	endtask

	// Monitor measures tick spacing and settles all queued notes
	always @(negedge i_clk) begin
		tog = tog + 8'(o_clock_output_pin !== pin_q);
		pin_q = o_clock_output_pin;
		if (o_bus_clk_tick === 1'b1) begin
			gap = cnt;
			cnt = 5'h01;
		end else
			cnt = cnt + 5'h01;
		while (q.size() > 0) begin
			check(q[0].id, val(q[0].id) & q[0].m, q[0].e);
			void'(q.pop_front());
		end
	end

	task automatic ex(int id, logic [7:0] e, logic [7:0] m = 8'hFF);
		q.push_back('{id, e, m});
	endtask
	task automatic step(int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	task automatic cfg(logic [7:0] d0, logic [7:0] d1);
		i_ctrl0_data = d0;
		i_ctrl1_data = d1;
		i_ctrl0_wr = 1;
		i_ctrl1_wr = 1;
		step(1);
		i_ctrl0_wr = 0;
		i_ctrl1_wr = 0;
	endtask
	task automatic pulse(int w);
		if (w == 0) begin
			i_ctrl1_data = 8'h21;
			i_ctrl1_wr = 1;
		end else if (w == 1)
			i_wait_exec = 1;
		else
			i_wake_irq = 1;
		step(1);
		i_ctrl1_wr = 0;
		i_wait_exec = 0;
		i_wake_irq = 0;
		step(2);
	endtask
	task automatic gap_is(logic [7:0] e);
		int t;
		t = 0;
		for (int k = 0; k < 200 && t < 4; k++) begin
			step(1);
			t += o_bus_clk_tick;
		end
		ex(2, e);
	endtask
	// Counts clock output pin changes over the next 80 clock edges
	task automatic toggles(logic [7:0] e);
		logic [7:0] b;
		b = tog;
		step(79);
		ex(8, b + e);
	endtask
	task automatic wake();
		pulse(2);
		ex(1, 8'h20);
		ex(3, 8'h3B);
	endtask

	task automatic final_report();
		$display("compares %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Hang guard, well above the roughly 1250 cycles needed
	always @(posedge i_clk) begin
		cyc++;
		if (cyc > 6000) begin
			fails++;
			final_report();
		end
	end

	initial begin
		{i_ctrl0_wr, i_ctrl1_wr, i_wait_exec, i_wake_irq, i_sub_clock, hold} = 6'h00;
		{i_ctrl0_data, i_ctrl1_data, i_port, i_strobe_n, i_bus_addr, i_bus_data, i_chip_select_lines} = 0;
		i_single_chip = 1;
		i_sys_rst = 1;
		step(8);
		i_sys_rst = 0;
		ex(0, 8'h48);
		ex(1, 8'h20);
		ex(3, 8'h3B);
		gap_is(8);
		$display("test reset done");
		for (int k = 0; k < 8; k++) begin
			cfg(k[2] ? 8'h48 : 8'h08, {k[1:0], 6'h20});
			gap_is(k[2] ? 8'h08 : (k[1:0] == 2'h3) ? 8'h10 : 8'h01 << k[1:0]);
		end
		cfg(8'h99, 8'h20);
		gap_is(10);
		ex(3, 8'h02, 8'h02);
		cfg(8'hB9, 8'h20);
		gap_is(10);
		ex(3, 8'h00, 8'h02);
		for (int k = 0; k < 8; k++) begin
			i_single_chip = k[2];
			cfg({6'h02, k[1:0]}, 8'h20);
			step(2);
			ex(4, {k[2] && k[1:0] != 2'h0, 7'h00}, 8'h80);
			toggles(k[2] ? tog_exp[k[1:0]] : 8'h00);
		end
		$display("test select done");
		i_single_chip = 0;
		hold = 1;
		step(2);
		va = i_bus_addr[7:0];
		vp = i_port;
		vd = i_bus_data[7:0];
		vc = {4'h0, i_chip_select_lines};
		pulse(0);
		hold = 0;
		ex(3, 8'h84);
		ex(0, 8'h4B);
		ex(5, 8'h7F);
		ex(4, 8'h20, 8'h20);
		step(3);
		ex(6, va);
		ex(7, vp);
		ex(9, vd);
		ex(10, vc);
		wake();
		gap_is(8);
		// sub output high in single-chip stop
		i_single_chip = 1;
		cfg(8'h09, 8'h20);
		step(1);
		pulse(0);
		step(1);
		ex(4, 8'hC0, 8'hC0);
		wake();
		$display("test stop done");
		// wait with peripheral stop, write refused
		cfg(8'h0E, 8'h00);
		pulse(1);
		ex(3, 8'h43, 8'hEF);
		cfg(8'h00, 8'hC0);
		ex(0, 8'h0E);
		toggles(8'h00);
		pulse(2);
		ex(1, 8'h00);
		gap_is(1);
		cfg(8'h0A, 8'h20);
		pulse(1);
		ex(3, 8'h63, 8'hEF);
		toggles(8'h14);
		wake();
		step(1);
		$display("test wait done");
		final_report();
	end
endmodule

bind scpm_clock_power scpm_chk #(.PORT_W(PORT_W)) u_chk (.*);
